// ### sgrr_consts.svh
/*
 * Constants of the serial gain control port: frame layout, reset values,
 * gain and fast-attack tables.
 * Assumes inclusion by the package and the design file only.
 */
`ifndef SGRR_CONSTS_SVH
`define SGRR_CONSTS_SVH

`define SGRR_FRAME_BITS 8
`define SGRR_RW_POS 7
`define SGRR_FA_HI_POS 6
`define SGRR_FA_LO_POS 5
`define SGRR_GAIN_MSB 4
`define SGRR_CTL_RESET 8'h18
`define SGRR_GAIN_DB_RESET 6'h08
`define SGRR_GAIN_MAX_DB 6'h20
`define SGRR_GAIN_MIN_DB 6'h02
`define SGRR_GAIN_FLOOR_CODE 5'h1e
`define SGRR_SEL_SERIAL 2'h1
`define SGRR_FA_STEP0_DB 5'h02
`define SGRR_FA_STEP1_DB 5'h04
`define SGRR_FA_STEP2_DB 5'h08
`define SGRR_FA_STEP3_DB 5'h10

`endif

// ### sgrr_pkg.sv
/*
 * Types of the serial gain control port.
 * Assumes the constants header is in the include path.
 */
package sgrr_pkg;
  `include "sgrr_consts.svh"

  typedef enum logic [2:0] {
    SGRR_IDLE = 3'h1,
    SGRR_WRITE = 3'h2,
    SGRR_READ = 3'h4
  } sgrr_state_t;

  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] din_sync;
    logic [1:0] sdio_sync;
    logic [1:0] sel_hi_sync;
    logic [1:0] sel_lo_sync;
    logic [1:0] fw_sync;
    logic [1:0] fa_sync;
    logic sck_prev;
    logic cs_prev;
    sgrr_state_t state;
    logic [7:0] shift;
    logic [3:0] count;
    logic rd_armed;
    logic [7:0] ctl;
    logic [5:0] gain_db;
    logic [7:0] rd_shift;
    logic rd_first;
    logic dout;
    logic out_en;
  } sgrr_regs_t;
endpackage : sgrr_pkg

// ### sgrr_port.sv
/*
 * Serial control port of a digitally controlled gain amplifier.
 * Assumes chip select, serial clock and data arrive asynchronously and
 * are much slower than mclk_i; the serial clock is sampled, not used.
 */
// Notes on behaviour
// - Gain in dB is 32 minus code; codes 30 and 31 give 2 dB.
// - Read-back exists only while the serial interface is selected.
// - A frame is a read only after a frame with read/write high.
// - Output bit changes on rising serial clock; host samples falling.
// - No continuous read; every read needs its own arming write.
// - Arming frame leaves gain and fast-attack bits unchanged.
// - Write frame: eight bits MSB first, flag, two step bits, gain.
// - Three-wire uses a two-way pin; four-wire separate in and out.
// - Fast-attack pin high adds 2, 4, 8 or 16 dB attenuation.
`include "sgrr_consts.svh"

module sgrr_port
  import sgrr_pkg::*;
(
  input wire logic mclk_i, // 200 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cs_n_i, // Chip select, active low
  input wire logic sclk_i, // Serial clock
  input wire logic sdi_i, // Four-wire data in
  input wire logic sdio_i, // Three-wire pin level
  output logic sdio_o, // Three-wire pin drive
  output logic sdio_oe_o, // Three-wire pin enable
  output logic sdo_o, // Four-wire data out
  output logic sdo_oe_o, // Four-wire data out enable
  input wire logic four_wire_i, // High selects four-wire wiring
  input wire logic iface_sel_hi_i, // Interface select, high pin
  input wire logic iface_sel_lo_i, // Interface select, low pin
  input wire logic fast_attenuate_pin_i, // Fast attack request
  output logic [4:0] gain_code_o, // Registered gain code
  output logic [1:0] fast_step_o, // Registered fast-attack step
  output logic [5:0] gain_db_o, // Effective gain in dB
  output logic serial_active_o // Serial interface selected
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Gain in dB for a code; the two top codes both sit at the floor.
  function automatic logic [5:0] code_to_db(input logic [4:0] code);
    if (code >= `SGRR_GAIN_FLOOR_CODE) begin
      return `SGRR_GAIN_MIN_DB;
    end
    return `SGRR_GAIN_MAX_DB - {1'b0, code};
  endfunction : code_to_db

  // Extra attenuation in dB for a fast-attack step selection.
  function automatic logic [4:0] step_db(input logic [1:0] sel);
    unique case (sel)
      2'h0: return `SGRR_FA_STEP0_DB;
      2'h1: return `SGRR_FA_STEP1_DB;
      2'h2: return `SGRR_FA_STEP2_DB;
      2'h3: return `SGRR_FA_STEP3_DB;
    endcase
    return `SGRR_FA_STEP0_DB;
  endfunction : step_db

  sgrr_regs_t q_r;
  sgrr_regs_t q_nxt;

  logic cs_n;
  logic sck;
  logic din;
  logic serial_en;
  logic sck_rise;
  logic frame_start;
  logic frame_end;
  logic [5:0] base_db;
  logic [5:0] atten_db;
  logic [5:0] eff_db;
  logic fw;
  logic fa;

  // ==========================================================
  // Synchronised pins and decode
  // ==========================================================
  assign cs_n = q_r.cs_sync[1];
  assign fw = q_r.fw_sync[1];
  assign fa = q_r.fa_sync[1];
  assign sck = q_r.sck_sync[1];
  assign serial_en = {q_r.sel_hi_sync[1], q_r.sel_lo_sync[1]}
    == `SGRR_SEL_SERIAL;
  assign din = fw ? q_r.din_sync[1] : q_r.sdio_sync[1];
  assign sck_rise = sck && !q_r.sck_prev;
  assign frame_start = q_r.cs_prev && !cs_n;
  assign frame_end = !q_r.cs_prev && cs_n;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    q_nxt = q_r;
    q_nxt.cs_sync = {q_r.cs_sync[0], cs_n_i};
    q_nxt.sck_sync = {q_r.sck_sync[0], sclk_i};
    q_nxt.din_sync = {q_r.din_sync[0], sdi_i};
    q_nxt.sdio_sync = {q_r.sdio_sync[0], sdio_i};
    q_nxt.sel_hi_sync = {q_r.sel_hi_sync[0], iface_sel_hi_i};
    q_nxt.sel_lo_sync = {q_r.sel_lo_sync[0], iface_sel_lo_i};
    q_nxt.fw_sync = {q_r.fw_sync[0], four_wire_i};
    q_nxt.fa_sync = {q_r.fa_sync[0], fast_attenuate_pin_i};
    // The effective gain is registered so the output never glitches.
    q_nxt.gain_db = eff_db;
    q_nxt.sck_prev = sck;
    q_nxt.cs_prev = cs_n;

    // Deselecting drops a pending arm, so a stale arm cannot turn the
    // next serial frame into a read.
    if (!serial_en) begin
      q_nxt.state = SGRR_IDLE;
      q_nxt.out_en = 1'b0;
      q_nxt.rd_armed = 1'b0;
    end else begin
      unique case (q_r.state)
        SGRR_IDLE: begin
          if (frame_start) begin
            q_nxt.count = 4'h0;
            if (q_r.rd_armed) begin
              // Current contents are captured at the frame start.
              q_nxt.state = SGRR_READ;
              q_nxt.rd_armed = 1'b0;
              q_nxt.rd_shift = q_r.ctl;
              q_nxt.rd_first = 1'b1;
              q_nxt.out_en = 1'b1;
            end else begin
              q_nxt.state = SGRR_WRITE;
            end
          end
        end
        SGRR_WRITE: begin
          if (frame_end) begin
            q_nxt.state = SGRR_IDLE;
            // A frame with fewer than eight rising edges is dropped whole; edges after the eighth are ignored.
            if (q_r.count == 4'(`SGRR_FRAME_BITS)) begin
              if (q_r.shift[`SGRR_RW_POS]) begin
                q_nxt.rd_armed = 1'b1;
              end else begin
                q_nxt.ctl = {1'b0, q_r.shift[6:0]};
              end
            end
          end else if (sck_rise && q_r.count < 4'(`SGRR_FRAME_BITS)) begin
            q_nxt.shift = {q_r.shift[6:0], din};
            q_nxt.count = q_r.count + 4'h1;
          end
        end
        SGRR_READ: begin
          if (frame_end) begin
            q_nxt.state = SGRR_IDLE;
            q_nxt.out_en = 1'b0;
          end else if (sck_rise) begin
            // First rising edge presents the MSB, later ones shift.
            if (q_r.rd_first) begin
              q_nxt.dout = q_r.rd_shift[7];
              q_nxt.rd_first = 1'b0;
            end else begin
              q_nxt.rd_shift = {q_r.rd_shift[6:0], 1'b0};
              q_nxt.dout = q_r.rd_shift[6];
            end
          end
        end
        default: q_nxt.state = SGRR_IDLE;
      endcase
    end
  end

  // Reset loads the idle pin levels into the edge detectors, so that no
  // false edge follows reset.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q_r <= '{
        cs_sync: 2'h3,
        sck_sync: 2'h0,
        din_sync: 2'h0,
        sdio_sync: 2'h0,
        sel_hi_sync: 2'h0,
        sel_lo_sync: 2'h0,
        fw_sync: 2'h0,
        fa_sync: 2'h0,
        sck_prev: 1'b0,
        cs_prev: 1'b1,
        state: SGRR_IDLE,
        shift: 8'h00,
        count: 4'h0,
        rd_armed: 1'b0,
        ctl: `SGRR_CTL_RESET,
        gain_db: `SGRR_GAIN_DB_RESET,
        rd_shift: 8'h00,
        rd_first: 1'b0,
        dout: 1'b0,
        out_en: 1'b0
      };
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign base_db = code_to_db(q_r.ctl[`SGRR_GAIN_MSB:0]);
  assign atten_db = fa ?
    {1'b0, step_db(q_r.ctl[`SGRR_FA_HI_POS:`SGRR_FA_LO_POS])} :
    6'h00;
  // Attenuation beyond the base gain clamps at 0 dB instead of wrapping.
  assign eff_db = (base_db > atten_db) ?
    base_db - atten_db : 6'h00;

  assign gain_code_o = q_r.ctl[`SGRR_GAIN_MSB:0];
  assign fast_step_o = q_r.ctl[`SGRR_FA_HI_POS:`SGRR_FA_LO_POS];
  assign gain_db_o = q_r.gain_db;
  assign serial_active_o = serial_en;
  assign sdio_o = q_r.dout;
  // Only the data pin of the strapped wiring mode is ever driven.
  assign sdio_oe_o = q_r.out_en && !fw;
  assign sdo_o = q_r.dout;
  assign sdo_oe_o = q_r.out_en && fw;

endmodule : sgrr_port

// ### sgrr_port_sva.sv
/* Assertions on the ports of the serial gain control port.
   Assumes binding to every sgrr_port instance. */
module sgrr_chk (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset, active high
  input wire logic cs_n_i, // Chip select pin
  input wire logic sclk_i, // Serial clock pin
  input wire logic four_wire_i, // Wiring strap
  input wire logic fast_attenuate_pin_i, // Fast attack pin
  input wire logic sdio_o, // Three-wire drive value
  input wire logic sdio_oe_o, // Three-wire drive enable
  input wire logic sdo_oe_o, // Four-wire drive enable
  input wire logic serial_active_o, // Serial interface selected
  input wire logic [4:0] gain_code_o, // Gain code
  input wire logic [1:0] fast_step_o, // Fast-attack step
  input wire logic [5:0] gain_db_o // Effective gain
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_oe_sel: assert property (
    (sdio_oe_o || sdo_oe_o) |-> $past(serial_active_o))
    else $error("oe unselected");
  a_three_wire: assert property (
    sdio_oe_o |-> !$past(four_wire_i, 2))
    else $error("sdio driven in four-wire");
  a_four_wire: assert property (
    sdo_oe_o |-> $past(four_wire_i, 2))
    else $error("sdo driven in three-wire");
  a_oe_after_cs: assert property (
    $rose(sdio_oe_o || sdo_oe_o) |-> $past(!cs_n_i, 2)) else $error("oe early");
  a_bit_on_rise: assert property (
    sdio_oe_o && !sclk_i && $past(!sclk_i, 8) && $past(sdio_oe_o, 8)
    |-> $stable(sdio_o)) else $error("data moved with clock low");
  a_gain_map: assert property (
    !$past(fast_attenuate_pin_i, 3) |-> gain_db_o ==
    (($past(gain_code_o) > 5'h1d) ? 6'h02 : 6'h20 - $past(gain_code_o)))
    else $error("gain map");
  a_fast_att: assert property (
    $past(fast_attenuate_pin_i, 3) && $past(gain_code_o) == 5'h00
    |-> gain_db_o == 6'h20 - (6'h02 << $past(fast_step_o)))
    else $error("fast step");
  a_ctl_frame: assert property (
    $changed({fast_step_o, gain_code_o}) |-> cs_n_i && serial_active_o)
    else $error("ctl moved inside frame");
endmodule : sgrr_chk

bind sgrr_port sgrr_chk chk (.*);

// ### sgrr_host.sv
/* Host model: frames the serial port, writes and reads one byte.
   Assumes a 200 MHz mclk_i; the serial clock idles low between frames. */
module sgrr_host (
  input wire logic mclk_i, // Bench clock
  input wire logic sdio_i, // Three-wire line level
  input wire logic sdo_i, // Four-wire read line
  output logic cs_n_o, // Chip select, active low
  output logic sclk_o, // Serial clock
  output logic sdi_o, // Four-wire data to the port
  output logic sdio_o, // Three-wire drive value
  output logic sdio_oe_o // Three-wire drive enable
);
  initial begin
    {cs_n_o, sclk_o, sdi_o, sdio_o, sdio_oe_o} = 5'h10;
  end
  task automatic frame(input logic [7:0] wd, input logic rd_en, four,
                       output logic [7:0] rd);
    cs_n_o <= 1'b0;
    sdio_oe_o <= !rd_en && !four;
    repeat (8) @(posedge mclk_i);
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= wd[i];
      sdio_o <= wd[i];
      repeat (8) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (16) @(posedge mclk_i);
      sclk_o <= 1'b0;
      rd[i] = four ? sdo_i : sdio_i;
      repeat (8) @(posedge mclk_i);
    end
    {cs_n_o, sdio_oe_o} <= 2'h2;
    repeat (12) @(posedge mclk_i);
  endtask : frame
endmodule : sgrr_host

// ### tb.sv
/* Self-checking bench of the serial gain control port.
   Assumes the host model drives every serial pin. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, four = 0, s_hi = 0, s_lo = 1, fa = 0, last = 0;
  logic cs_n, sclk, sdi, h_d, h_oe, d_o, d_oe, sdo, sdo_oe, act, line;
  logic [4:0] code;
  logic [1:0] step;
  logic [5:0] db;
  logic [7:0] rd;
  int fail_count = 0, checks = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  assign line = d_oe ? d_o : (h_oe ? h_d : ~last);
  always @(posedge mclk) if (d_oe || h_oe) last <= line;
  sgrr_port uut (.mclk_i(mclk), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk),
    .sdi_i(sdi), .sdio_i(line), .sdio_o(d_o), .sdio_oe_o(d_oe), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .four_wire_i(four), .iface_sel_hi_i(s_hi),
    .iface_sel_lo_i(s_lo), .fast_attenuate_pin_i(fa), .gain_code_o(code),
    .fast_step_o(step), .gain_db_o(db), .serial_active_o(act));
  sgrr_host host (.mclk_i(mclk), .sdio_i(line), .sdo_i(sdo_oe ? sdo : ~sdo),
    .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdio_o(h_d), .sdio_oe_o(h_oe));
  task automatic cmp(input logic [7:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  function automatic logic [7:0] exp_db(logic [4:0] c, logic [1:0] s, f);
    logic [7:0] g;
    g = (c > 5'h1d) ? 8'h02 : 8'h20 - c;
    if (f) g = (g > (8'h02 << s)) ? g - (8'h02 << s) : 8'h00;
    return g;
  endfunction : exp_db
  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    cmp({act, step, code}, 8'h98, "reset ctl");
    cmp({sdo_oe, d_oe, db}, 8'h08, "reset gain");
    for (int i = 0; i < 10; i++) begin
      fa <= i[2] | (i == 0);
      host.frame({1'b0, i[1:0], 5'(i * 10)}, 1'b0, 1'b0, rd);
      cmp({1'b0, step, code}, {1'b0, i[1:0], 5'(i * 10)}, "write");
      cmp({2'h0, db}, exp_db(5'(i * 10), i[1:0], fa), "gain");
    end
    host.frame(8'hff, 1'b0, 1'b0, rd);
    cmp({1'b0, step, code}, 8'h3a, "arm keeps ctl");
    host.frame(8'h00, 1'b1, 1'b0, rd);
    cmp(rd, 8'h3a, "read three-wire");
    host.frame(8'h45, 1'b0, 1'b0, rd);
    cmp({1'b0, step, code}, 8'h45, "no second read");
    four <= 1'b1;
    host.frame(8'h80, 1'b0, 1'b1, rd);
    host.frame(8'h00, 1'b1, 1'b1, rd);
    cmp(rd, 8'h45, "read four-wire");
    {four, s_hi, s_lo} <= 3'h2;
    repeat (8) @(posedge mclk);
    host.frame(8'h1f, 1'b0, 1'b0, rd);
    cmp({act, step, code}, 8'h45, "deselected");
    give_verdict();
  end
endmodule : tb
